// *** exrp_pkg.sv ***
// exrp_pkg: constants for the exception recognition and priority unit
// assumes 32-bit state words, big-endian bit numbering mapped to [31:0]
package exrp_pkg;
  // wishbone register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_MSW = 8'h04;
  localparam logic [7:0] ADDR_PREFIX = 8'h08;
  localparam logic [7:0] ADDR_ROFS = 8'h0c;
  localparam logic [7:0] ADDR_SPC = 8'h10;
  localparam logic [7:0] ADDR_SST = 8'h14;
  localparam logic [7:0] ADDR_SYND = 8'h18;
  localparam logic [7:0] ADDR_MCSYN = 8'h1c;
  localparam logic [7:0] ADDR_DFA = 8'h20;
  localparam logic [7:0] ADDR_STAT = 8'h24;
  localparam logic [7:0] ADDR_PEND = 8'h28;
  // machine state word bits ([31-n] for architectural bit n)
  localparam int MSW_USER_CACHE_LOCK_EN = 5;
  localparam int MSW_VEC = 6;
  localparam int MSW_WE = 13;
  localparam int MSW_CE = 14;
  localparam int MSW_EE = 15;
  localparam int MSW_ME = 19;
  localparam int MSW_RI = 30;
  // syndrome bits
  localparam int SYN_VEC = 7;
  localparam int SYN_VLE = 5;
  // control bits
  localparam int CTL_INEXACT_EN = 0;
  localparam int CTL_DEBUG_EN = 1;
  localparam logic [31:0] MSW_RESET = 32'h0000_0000;
  localparam logic [31:0] VEC_RESET = 32'hffff_fffc;
  localparam logic [11:0] MC_OFFSET = 12'h010;
  // number of pending sources for recoverable async requests
  localparam int NASYNC = 6;
  typedef enum logic [4:0] {
    EXRP_IDLE = 5'h01,
    EXRP_TAKE = 5'h02,
    EXRP_MC = 5'h04,
    EXRP_RESET = 5'h08,
    EXRP_ROUND = 5'h10
  } exrp_state_e;
endpackage

// *** exrp_unit.sv ***
// exrp_unit: exception recognition, prioritisation and round interrupt entry
// assumes pipeline signals on clk_i; pins are asynchronous and synchronised here
`timescale 1ns/1ps
module exrp_unit #(
  parameter int WIDTH = 32
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins, active low
  input wire logic reset_pin_n_i,
  input wire logic nmi_pin_n_i,
  input wire logic mcp_pin_n_i,
  // internal reset requests
  input wire logic wdog_reset_i,
  input wire logic dbg_reset_i,
  // machine check causes from the pipeline
  input wire logic handler_fetch_fault_i,
  input wire logic store_bus_err_i,
  input wire logic bus_transfer_error_i,
  // recoverable async sources: ext, fit, dec, crit, dbg, wdog
  input wire logic [exrp_pkg::NASYNC-1:0] async_req_i,
  input wire logic recoverable_i,
  // fetch stage
  input wire logic fetch_fault_i,
  input wire logic fetch_next_i,
  input wire logic redirect_i,
  // execution stage
  input wire logic exec_fault_i,
  input wire logic older_done_i,
  input wire logic older_fault_i,
  input wire logic vec_inexact_i,
  input wire logic varlen_i,
  input wire logic [WIDTH-1:0] next_pc_i,
  // completion
  input wire logic regs_updated_i,
  input wire logic retire_i,
  input wire logic post_dbg_i,
  // outputs
  output logic take_o,
  output logic [3:0] cause_o,
  output logic [WIDTH-1:0] vector_o,
  output logic core_reset_o,
  output logic complete_o,
  output logic irq_taken_dbg_o,
  output logic crit_overwrite_o
);
  logic [1:0] rstp_r, nmip_r, mcpp_r;
  logic [31:0] ctrl_r, msw_r, prefix_r, rofs_r, spc_r, sst_r, synd_r, mcsyn_r, dfa_r;
  logic [exrp_pkg::NASYNC-1:0] apend_r;
  logic ftag_r, xpend_r, round_r, pdbg_r;
  logic wr, rd_hit;
  logic sys_rst, mc_req, async_go, fetch_go, exec_go, round_go;
  exrp_pkg::exrp_state_e state_r;

  // two-stage synchronisers for pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rstp_r <= 2'h3;
      nmip_r <= 2'h3;
      mcpp_r <= 2'h3;
    end else begin
      rstp_r <= {rstp_r[0], reset_pin_n_i};
      nmip_r <= {nmip_r[0], nmi_pin_n_i};
      mcpp_r <= {mcpp_r[0], mcp_pin_n_i};
    end
  end

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & (&wb_sel_i);
  assign sys_rst = ~rstp_r[1] | wdog_reset_i | dbg_reset_i;
  assign mc_req = ~mcpp_r[1] | ~nmip_r[1] | handler_fetch_fault_i | store_bus_err_i
    | (bus_transfer_error_i & ~msw_r[exrp_pkg::MSW_EE] & msw_r[exrp_pkg::MSW_ME]);
  assign async_go = (|apend_r) & recoverable_i;
  assign fetch_go = ftag_r & fetch_next_i & recoverable_i & ~redirect_i;
  assign exec_go = xpend_r & older_done_i & ~older_fault_i;
  assign round_go = round_r & older_done_i & ~older_fault_i;

  // wishbone ack and read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      case (wb_adr_i)
        exrp_pkg::ADDR_CTRL: wb_dat_o <= ctrl_r;
        exrp_pkg::ADDR_MSW: wb_dat_o <= msw_r;
        exrp_pkg::ADDR_PREFIX: wb_dat_o <= prefix_r;
        exrp_pkg::ADDR_ROFS: wb_dat_o <= rofs_r;
        exrp_pkg::ADDR_SPC: wb_dat_o <= spc_r;
        exrp_pkg::ADDR_SST: wb_dat_o <= sst_r;
        exrp_pkg::ADDR_SYND: wb_dat_o <= synd_r;
        exrp_pkg::ADDR_MCSYN: wb_dat_o <= mcsyn_r;
        exrp_pkg::ADDR_DFA: wb_dat_o <= dfa_r;
        exrp_pkg::ADDR_STAT: wb_dat_o <= {27'h0, state_r};
        exrp_pkg::ADDR_PEND: wb_dat_o <= {22'h0, pdbg_r, round_r, xpend_r, ftag_r, apend_r};
        default: wb_dat_o <= 32'h0;
      endcase
    end
  end

  // plain software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_r <= 32'h0;
      prefix_r <= 32'h0;
      rofs_r <= 32'h0;
      mcsyn_r <= 32'h0;
      dfa_r <= 32'h0;
    end else if (wr) begin
      case (wb_adr_i)
        exrp_pkg::ADDR_CTRL: ctrl_r <= wb_dat_i;
        exrp_pkg::ADDR_PREFIX: prefix_r <= wb_dat_i;
        exrp_pkg::ADDR_ROFS: rofs_r <= wb_dat_i;
        exrp_pkg::ADDR_MCSYN: mcsyn_r <= wb_dat_i;
        exrp_pkg::ADDR_DFA: dfa_r <= wb_dat_i;
        default: ;
      endcase
    end
  end

  // recoverable async pending, set wins over software cancel
  always_ff @(posedge clk_i) begin
    if (rst_i | sys_rst) begin
      apend_r <= '0;
    end else begin
      apend_r <= ((wr && wb_adr_i == exrp_pkg::ADDR_PEND) ? apend_r & ~wb_dat_i[5:0] : apend_r)
        & ~((!mc_req && async_go) ? apend_r : '0)
        | async_req_i;
    end
  end

  // fetch tag, exec and round pending
  always_ff @(posedge clk_i) begin
    if (rst_i | sys_rst | mc_req) begin
      ftag_r <= 1'b0;
      xpend_r <= 1'b0;
      round_r <= 1'b0;
    end else begin
      if (redirect_i) ftag_r <= 1'b0;
      else if (fetch_fault_i) ftag_r <= 1'b1;
      else if (fetch_go && !async_go) ftag_r <= 1'b0;
      if (older_fault_i) begin
        xpend_r <= 1'b0;
        round_r <= 1'b0;
      end else begin
        if (exec_fault_i) xpend_r <= 1'b1;
        else if (exec_go) xpend_r <= 1'b0;
        if (vec_inexact_i && ctrl_r[exrp_pkg::CTL_INEXACT_EN]) round_r <= 1'b1;
        else if (round_go) round_r <= 1'b0;
      end
    end
  end

  // completion and post-execution debug
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      complete_o <= 1'b0;
      pdbg_r <= 1'b0;
    end else begin
      complete_o <= regs_updated_i & retire_i;
      pdbg_r <= regs_updated_i & retire_i & post_dbg_i & ctrl_r[exrp_pkg::CTL_DEBUG_EN]
        & ~(older_fault_i | exec_fault_i | mc_req | sys_rst);
    end
  end

  // priority resolution and state save
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= exrp_pkg::EXRP_RESET;
      msw_r <= exrp_pkg::MSW_RESET;
      spc_r <= 32'h0;
      sst_r <= 32'h0;
      synd_r <= 32'h0;
      take_o <= 1'b0;
      cause_o <= 4'h0;
      vector_o <= '0;
      core_reset_o <= 1'b1;
      irq_taken_dbg_o <= 1'b0;
      crit_overwrite_o <= 1'b0;
    end else begin
      take_o <= 1'b0;
      core_reset_o <= 1'b0;
      irq_taken_dbg_o <= 1'b0;
      crit_overwrite_o <= 1'b0;
      if (wr && wb_adr_i == exrp_pkg::ADDR_MSW) msw_r <= wb_dat_i;
      if (sys_rst) begin
        state_r <= exrp_pkg::EXRP_RESET;
        msw_r <= exrp_pkg::MSW_RESET;
        synd_r <= 32'h0;
        core_reset_o <= 1'b1;
        take_o <= 1'b1;
        cause_o <= 4'h0;
        vector_o <= exrp_pkg::VEC_RESET;
      end else if (mc_req) begin
        state_r <= exrp_pkg::EXRP_MC;
        sst_r <= msw_r;
        msw_r[exrp_pkg::MSW_ME] <= 1'b0;
        msw_r[exrp_pkg::MSW_EE] <= 1'b0;
        crit_overwrite_o <= 1'b1;
        take_o <= 1'b1;
        irq_taken_dbg_o <= ctrl_r[exrp_pkg::CTL_DEBUG_EN];
        cause_o <= 4'h1;
        vector_o <= {prefix_r[31:16], 4'h0, exrp_pkg::MC_OFFSET[7:0], 4'h0};
      end else if (async_go || fetch_go || exec_go || round_go) begin
        state_r <= round_go && !(async_go || fetch_go || exec_go) ? exrp_pkg::EXRP_ROUND
          : exrp_pkg::EXRP_TAKE;
        take_o <= 1'b1;
        irq_taken_dbg_o <= ctrl_r[exrp_pkg::CTL_DEBUG_EN];
        cause_o <= async_go ? 4'h4 : fetch_go ? 4'h9 : exec_go ? 4'hc : 4'he;
        if (!async_go && !fetch_go && !exec_go) begin
          spc_r <= next_pc_i;
          sst_r <= msw_r;
          synd_r <= 32'h0;
          synd_r[exrp_pkg::SYN_VEC] <= 1'b1;
          synd_r[exrp_pkg::SYN_VLE] <= varlen_i;
          msw_r[exrp_pkg::MSW_USER_CACHE_LOCK_EN] <= 1'b0;
          msw_r[exrp_pkg::MSW_VEC] <= 1'b0;
          msw_r[exrp_pkg::MSW_WE] <= 1'b0;
          msw_r[exrp_pkg::MSW_EE] <= 1'b0;
          vector_o <= {prefix_r[31:16], rofs_r[15:4], 4'h0};
        end else begin
          vector_o <= {prefix_r[31:16], 16'h0};
        end
      end else begin
        state_r <= exrp_pkg::EXRP_IDLE;
      end
    end
  end

  // round entry leaves critical enable and its prefix, offset alone
  property p_round_entry;
    @(posedge clk_i) disable iff (rst_i)
    (round_go && !async_go && !fetch_go && !exec_go && !sys_rst && !mc_req) |=>
      (take_o && vector_o == {$past(prefix_r[31:16]), $past(rofs_r[15:4]), 4'h0}
       && msw_r[exrp_pkg::MSW_CE] == $past(msw_r[exrp_pkg::MSW_CE]));
  endproperty
  a_round_entry: assert property (p_round_entry) else $error("round entry wrong");

  property p_round_save;
    @(posedge clk_i) disable iff (rst_i)
    (round_go && !async_go && !fetch_go && !exec_go && !sys_rst && !mc_req) |=>
      (spc_r == $past(next_pc_i) && sst_r == $past(msw_r) && synd_r[exrp_pkg::SYN_VEC]
       && !msw_r[exrp_pkg::MSW_EE] && mcsyn_r == $past(mcsyn_r));
  endproperty
  a_round_save: assert property (p_round_save) else $error("round save wrong");

  property p_reset_first;
    @(posedge clk_i) disable iff (rst_i)
    sys_rst |=> (core_reset_o && cause_o == 4'h0 && vector_o == exrp_pkg::VEC_RESET);
  endproperty
  a_reset_first: assert property (p_reset_first) else $error("reset not taken");

  property p_mc_first;
    @(posedge clk_i) disable iff (rst_i)
    (mc_req && !sys_rst) |=> (take_o && cause_o == 4'h1 && crit_overwrite_o);
  endproperty
  a_mc_first: assert property (p_mc_first) else $error("machine check deferred");

  property p_async_wait;
    @(posedge clk_i) disable iff (rst_i)
    (|apend_r && !recoverable_i && !sys_rst && !mc_req && !fetch_go && !exec_go && !round_go)
      |=> !take_o;
  endproperty
  a_async_wait: assert property (p_async_wait) else $error("async taken early");

  property p_redirect_drop;
    @(posedge clk_i) disable iff (rst_i)
    redirect_i |=> !ftag_r;
  endproperty
  a_redirect_drop: assert property (p_redirect_drop) else $error("fetch tag kept");

  property p_older_wins;
    @(posedge clk_i) disable iff (rst_i)
    older_fault_i |=> (!xpend_r && !round_r);
  endproperty
  a_older_wins: assert property (p_older_wins) else $error("pending not discarded");

  property p_complete;
    @(posedge clk_i) disable iff (rst_i)
    complete_o |-> $past(regs_updated_i) && $past(retire_i);
  endproperty
  a_complete: assert property (p_complete) else $error("early completion");

  property p_round_raise;
    @(posedge clk_i) disable iff (rst_i)
    (vec_inexact_i && ctrl_r[exrp_pkg::CTL_INEXACT_EN] && !older_fault_i
     && !sys_rst && !mc_req) |=> round_r;
  endproperty
  a_round_raise: assert property (p_round_raise) else $error("round not raised");

  property p_round_status;
    @(posedge clk_i) disable iff (rst_i)
    (round_go && !async_go && !fetch_go && !exec_go && !sys_rst && !mc_req) |=>
      (sst_r == $past(msw_r) && state_r == exrp_pkg::EXRP_ROUND);
  endproperty
  a_round_status: assert property (p_round_status) else $error("status not saved");

  property p_round_synd;
    @(posedge clk_i) disable iff (rst_i)
    (round_go && !async_go && !fetch_go && !exec_go && !sys_rst && !mc_req) |=>
      (synd_r[exrp_pkg::SYN_VLE] == $past(varlen_i) && synd_r[exrp_pkg::SYN_VEC]
       && (synd_r & ~(32'h1 << exrp_pkg::SYN_VEC) & ~(32'h1 << exrp_pkg::SYN_VLE)) == 32'h0);
  endproperty
  a_round_synd: assert property (p_round_synd) else $error("syndrome wrong");

  property p_round_msw;
    @(posedge clk_i) disable iff (rst_i)
    (round_go && !async_go && !fetch_go && !exec_go && !sys_rst && !mc_req) |=>
      (!msw_r[exrp_pkg::MSW_USER_CACHE_LOCK_EN] && !msw_r[exrp_pkg::MSW_VEC] && !msw_r[exrp_pkg::MSW_WE]
       && dfa_r == $past(dfa_r));
  endproperty
  a_round_msw: assert property (p_round_msw) else $error("state bits not cleared");

  property p_nmi_crit;
    @(posedge clk_i) disable iff (rst_i)
    (!nmip_r[1] && !sys_rst) |=> (take_o && crit_overwrite_o && cause_o == 4'h1);
  endproperty
  a_nmi_crit: assert property (p_nmi_crit) else $error("nmi not taken");

  property p_irq_dbg;
    @(posedge clk_i) disable iff (rst_i)
    irq_taken_dbg_o == (take_o && !core_reset_o && $past(ctrl_r[exrp_pkg::CTL_DEBUG_EN]));
  endproperty
  a_irq_dbg: assert property (p_irq_dbg) else $error("taken debug event wrong");

  property p_fetch_wait;
    @(posedge clk_i) disable iff (rst_i)
    (ftag_r && !(fetch_next_i && recoverable_i) && !sys_rst && !mc_req && !async_go
     && !exec_go && !round_go) |=> !take_o;
  endproperty
  a_fetch_wait: assert property (p_fetch_wait) else $error("fetch fault taken early");

  property p_exec_wait;
    @(posedge clk_i) disable iff (rst_i)
    (xpend_r && !older_done_i && !sys_rst && !mc_req && !async_go && !fetch_go
     && !round_go) |=> !take_o;
  endproperty
  a_exec_wait: assert property (p_exec_wait) else $error("exec fault taken early");

  property p_post_drop;
    @(posedge clk_i) disable iff (rst_i)
    (older_fault_i || exec_fault_i || mc_req || sys_rst) |=> !pdbg_r;
  endproperty
  a_post_drop: assert property (p_post_drop) else $error("post debug kept");

  property p_bus_err_masked;
    @(posedge clk_i) disable iff (rst_i)
    (bus_transfer_error_i && msw_r[exrp_pkg::MSW_EE] && mcpp_r[1] && nmip_r[1]
     && !handler_fetch_fault_i && !store_bus_err_i) |=> !crit_overwrite_o;
  endproperty
  a_bus_err_masked: assert property (p_bus_err_masked) else $error("masked bus error");
endmodule

// *** exrp_pin_model.sv ***
// exrp_pin_model: far-side request pins, reset, nmi and machine check
// assumes fire_i from the bench on clk_i; idle pins sit high as if pulled up
`timescale 1ns/1ps
module exrp_pin_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] fire_i,
  output logic [2:0] pin_n_o
);
  // one low cycle per fire, bit0 reset, bit1 nmi, bit2 machine check
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_n_o <= 3'h7;
    end else begin
      pin_n_o <= ~fire_i;
    end
  end
endmodule

// *** tb_exrp_unit.sv ***
// tb_exrp_unit: self-checking bench for the exception unit
// assumes the pin model on the far side and a classic wishbone master here
`timescale 1ns/1ps
module tb_exrp_unit;
  typedef struct packed {logic [3:0] c; logic [31:0] v; logic d; logic x;} exrp_exp_s;
  localparam logic [13:0] WD = 14'h0001, DR = 14'h0002, HF = 14'h0004, SB = 14'h0008;
  localparam logic [13:0] BT = 14'h0010, RC = 14'h0020, FF = 14'h0040, FN = 14'h0080;
  localparam logic [13:0] RD = 14'h0100, EF = 14'h0200, OD = 14'h0400, OF = 14'h0800;
  localparam logic [13:0] VI = 14'h1000, VL = 14'h2000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc = 1'b0;
  logic wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_dat = 32'h0, npc = 32'h0, pre, rofs, q;
  logic [13:0] p = 14'h0;
  logic [5:0] areq = 6'h0;
  logic [2:0] fire = 3'h0;
  logic ru = 1'b0, rt = 1'b0, cr_r = 1'b0, on_r = 1'b0, pd = 1'b0;
  logic [31:0] wb_dat_o, vector_o, rnd, seed = 32'h184dce48;
  logic wb_ack_o, take_o, core_reset_o, complete_o, irq_taken_dbg_o, crit_overwrite_o;
  logic [3:0] cause_o;
  logic [2:0] pin_n;
  exrp_exp_s expq[$];
  exrp_exp_s e;
  int n_fail = 0, num_checks = 0, cyc_cnt = 0;
  initial forever #4 clk_i = ~clk_i;
  exrp_pin_model u_pins (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .pin_n_o(pin_n));
  exrp_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_cyc),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(4'hf), .wb_dat_i(wb_dat),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .reset_pin_n_i(pin_n[0]),
    .nmi_pin_n_i(pin_n[1]), .mcp_pin_n_i(pin_n[2]), .wdog_reset_i(p[0]), .dbg_reset_i(p[1]),
    .handler_fetch_fault_i(p[2]), .store_bus_err_i(p[3]), .bus_transfer_error_i(p[4]),
    .async_req_i(areq), .recoverable_i(p[5]), .fetch_fault_i(p[6]), .fetch_next_i(p[7]),
    .redirect_i(p[8]), .exec_fault_i(p[9]), .older_done_i(p[10]), .older_fault_i(p[11]),
    .vec_inexact_i(p[12]), .varlen_i(p[13]), .next_pc_i(npc), .regs_updated_i(ru),
    .retire_i(rt), .post_dbg_i(pd), .take_o(take_o), .cause_o(cause_o),
    .vector_o(vector_o), .core_reset_o(core_reset_o), .complete_o(complete_o),
    .irq_taken_dbg_o(irq_taken_dbg_o), .crit_overwrite_o(crit_overwrite_o));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_we <= w;
    wb_adr <= a;
    wb_dat <= d;
    @(posedge clk_i iff wb_ack_o === 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(q, exp);
  endtask
  task automatic drv(input logic [13:0] m, input logic [5:0] a, input int n);
    @(posedge clk_i);
    p <= m;
    areq <= a;
    repeat (n) @(posedge clk_i);
    p <= 14'h0;
    areq <= 6'h0;
    repeat (6) @(posedge clk_i);
  endtask
  task automatic ex(input logic [3:0] c, input logic [31:0] v, input logic d, input logic x);
    expq.push_back('{c, v, d, x});
  endtask
  // random completion traffic and its one-cycle echo
  always @(posedge clk_i) begin
    rnd = xs();
    ru <= rnd[0];
    rt <= rnd[1];
    pd <= rnd[2];
    cr_r <= ru & rt;
    on_r <= !rst_i;
    if (on_r && !rst_i && p == 14'h0) check(complete_o, cr_r);
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      n_fail++;
      finish_test();
    end
  end
  // non-reset takes (cause_o not 0) are matched against the oldest noted expectation
  always @(posedge clk_i) begin
    if (!rst_i && take_o === 1'b1 && cause_o !== 4'h0) begin
      if (expq.size() == 0) check(1'b1, 1'b0);
      else begin
        e = expq.pop_front();
        check(cause_o, e.c);
        check(vector_o, e.v);
        check(irq_taken_dbg_o, e.d);
        check(crit_overwrite_o, e.x);
      end
    end
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    npc <= xs();
    pre = xs() & 32'hffff0000;
    rofs = xs() & 32'h0000fff0;
    wb(1'b1, exrp_pkg::ADDR_CTRL, 32'h0);
    wb(1'b1, exrp_pkg::ADDR_MSW, 32'h0008e060);
    wb(1'b1, exrp_pkg::ADDR_PREFIX, pre);
    wb(1'b1, exrp_pkg::ADDR_ROFS, rofs);
    wb(1'b1, exrp_pkg::ADDR_MCSYN, 32'h00005a5a);
    wb(1'b1, exrp_pkg::ADDR_DFA, 32'h0000c3c3);
    drv(VI, 6'h0, 1);
    drv(OD, 6'h0, 2);
    wb(1'b1, exrp_pkg::ADDR_CTRL, 32'h3);
    ex(4'he, pre | rofs, 1'b1, 1'b0);
    drv(VI, 6'h0, 1);
    drv(OD | VL, 6'h0, 2);
    rd(exrp_pkg::ADDR_SPC, npc);
    rd(exrp_pkg::ADDR_SST, 32'h0008e060);
    rd(exrp_pkg::ADDR_SYND, 32'h000000a0);
    rd(exrp_pkg::ADDR_MSW, 32'h00084000);
    rd(exrp_pkg::ADDR_MCSYN, 32'h00005a5a);
    rd(exrp_pkg::ADDR_DFA, 32'h0000c3c3);
    rd(8'h3c, 32'h0);
    $display("test round done");
    drv(EF, 6'h0, 1);
    drv(OF, 6'h0, 1);
    drv(OD, 6'h0, 2);
    ex(4'hc, pre, 1'b1, 1'b0);
    drv(EF, 6'h0, 1);
    drv(OD, 6'h0, 2);
    drv(FF, 6'h0, 1);
    drv(RD, 6'h0, 1);
    drv(FN | RC, 6'h0, 1);
    ex(4'h9, pre, 1'b1, 1'b0);
    drv(FF, 6'h0, 1);
    drv(FN | RC, 6'h0, 1);
    $display("test sync faults done");
    wb(1'b1, exrp_pkg::ADDR_MSW, 32'h00088000);
    for (int i = 0; i < 6; i++) begin
      drv(14'h0, 6'h1 << i, 1);
      ex(4'h4, pre, 1'b1, 1'b0);
      drv(RC, 6'h0, 1);
    end
    drv(14'h0, 6'h1, 1);
    wb(1'b1, exrp_pkg::ADDR_PEND, 32'h1);
    drv(RC, 6'h0, 1);
    drv(BT, 6'h0, 1);
    ex(4'h1, pre | 32'h100, 1'b1, 1'b1);
    ex(4'h4, pre, 1'b1, 1'b0);
    drv(14'h0, 6'h2, 1);
    drv(SB | RC, 6'h0, 1);
    drv(RC, 6'h0, 1);
    $display("test async done");
    wb(1'b1, exrp_pkg::ADDR_CTRL, 32'h1);
    wb(1'b1, exrp_pkg::ADDR_MSW, 32'h00080000);
    for (int i = 2; i < 7; i++) begin
      wb(1'b1, exrp_pkg::ADDR_MSW, 32'h00080000);
      ex(4'h1, pre | 32'h100, 1'b0, 1'b1);
      if (i < 5) drv(14'h1 << i, 6'h0, 1);
      else begin
        fire <= 3'h1 << (i - 4);
        @(posedge clk_i);
        fire <= 3'h0;
        repeat (8) @(posedge clk_i);
      end
    end
    $display("test machine check done");
    for (int i = 0; i < 3; i++) begin
      drv(14'h0, 6'h1, 1);
      fire <= (i == 2) ? 3'h1 : 3'h0;
      p <= (i < 2) ? (14'h1 << i) : 14'h0;
      q = 32'h0;
      repeat (8) begin
        @(posedge clk_i);
        fire <= 3'h0;
        p <= 14'h0;
        if (core_reset_o === 1'b1) q = 32'h1;
      end
      check(q, 32'h1);
      repeat (6) @(posedge clk_i);
    end
    $display("test reset done");
    check(expq.size(), 32'h0);
    finish_test();
  end
endmodule
